// [core/fcl_map.svh]
// Constants for the floating-point compare-less unit.
// Overview of operation
// - Flags op returns exception vector of a<=b
// - Returned vector uses status word bit layout
// - Flags op leaves status word flags alone
// - Denormal operand becomes zero, sets flush bit
// - Guard bit 0 low keeps destination unchanged
// - Less-equal flags equals swapped greater-equal flags
// - Less-than writes 1 if a<b, else 0
// - Operands are IEEE single precision
// - Less-than denormal flushes, sets status flush flag
// - Less-than exceptions set sticky status flags
// - Status flags update with destination write
// - Concurrent status updates OR with old value; an explicit status write replaces it and wins
// - False guard blocks destination and status update
// - Less-than equals swapped greater-than
`ifndef FCL_MAP_SVH
`define FCL_MAP_SVH
`define FCL_DATA_W 32
`define FCL_FLAG_W 6
`define FCL_INV_BIT 4
`define FCL_IFZ_BIT 5
`define FCL_EXP_MSB 30
`define FCL_EXP_LSB 23
`define FCL_FRAC_MSB 22
`define FCL_LATENCY 1
`endif

// [core/fcl_pkg.sv]
// Types for the floating-point compare-less unit.
package fcl_pkg;
   typedef enum logic [1:0] {
      FCL_OP_LEQ_FLAGS = 2'h1,
      FCL_OP_LESS = 2'h2
   } fcl_op_t;
   typedef struct packed {
      logic valid;
      fcl_op_t op;
      logic [31:0] first_source;
      logic [31:0] second_source;
      logic [31:0] guard;
      logic [4:0] dest;
   } fcl_issue_t;
   typedef struct packed {
      logic valid;
      logic [4:0] dest;
      logic [31:0] data;
   } fcl_result_t;
endpackage

// [core/fcl_cmp_core.sv]
// Combinational single-precision compare with denormal flushing.
`timescale 1ns/1ps
`default_nettype none
`include "fcl_map.svh"
module fcl_cmp_core
   import fcl_pkg::*;
(
   // Operands.
   input wire logic [31:0] a_in,
   input wire logic [31:0] b_in,
   // Results.
   output logic lt_out,
   output logic eq_out,
   output logic nan_out,
   output logic ifz_out
);
   logic a_den, b_den, a_nan, b_nan, a_zero, b_zero, mag_lt;
   logic [30:0] a_mag, b_mag;
   always_comb begin
      a_den = (a_in[`FCL_EXP_MSB:`FCL_EXP_LSB] == 8'h00) && (a_in[`FCL_FRAC_MSB:0] != 23'h0);
      b_den = (b_in[`FCL_EXP_MSB:`FCL_EXP_LSB] == 8'h00) && (b_in[`FCL_FRAC_MSB:0] != 23'h0);
      a_nan = (a_in[`FCL_EXP_MSB:`FCL_EXP_LSB] == 8'hff) && (a_in[`FCL_FRAC_MSB:0] != 23'h0);
      b_nan = (b_in[`FCL_EXP_MSB:`FCL_EXP_LSB] == 8'hff) && (b_in[`FCL_FRAC_MSB:0] != 23'h0);
      a_mag = a_den ? 31'h0 : a_in[30:0];
      b_mag = b_den ? 31'h0 : b_in[30:0];
      a_zero = (a_mag == 31'h0);
      b_zero = (b_mag == 31'h0);
      nan_out = a_nan | b_nan;
      ifz_out = a_den | b_den;
      eq_out = !nan_out && ((a_zero && b_zero) || (a_in[31] == b_in[31] && a_mag == b_mag));
      if (a_in[31] != b_in[31]) begin
         mag_lt = a_in[31];
      end else if (a_in[31]) begin
         mag_lt = a_mag > b_mag;
      end else begin
         mag_lt = a_mag < b_mag;
      end
      lt_out = !nan_out && !eq_out && mag_lt;
   end
endmodule
`default_nettype wire

// [core/fcl_unit.sv]
// Floating-point compare-less unit: flags compare and less-than with status update.
`timescale 1ns/1ps
`default_nettype none
`include "fcl_map.svh"
module fcl_unit
   import fcl_pkg::*;
#(
   // Operand width, flag vector width and result delay.
   parameter int DATA_W = `FCL_DATA_W,
   parameter int FLAG_W = `FCL_FLAG_W,
   parameter int LATENCY = `FCL_LATENCY
)
(
   // Clock and reset.
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   // Issue.
   input wire fcl_issue_t ISSUE_IN,
   // Status word flags from other units and explicit status writes.
   input wire logic [5:0] OTHER_FLAGS_IN,
   input wire logic PSW_WRITE_IN,
   input wire logic [5:0] PSW_WDATA_IN,
   // Results.
   output fcl_result_t RESULT_OUT,
   output logic [5:0] PSW_FLAGS_OUT
);
   // Compare core outputs.
   logic lt;
   logic eq;
   logic nan;
   logic input_flush_zero_flag;

   // Decoded issue.
   logic issue_valid;
   logic guard_ok;
   logic op_is_flags;
   logic op_is_less;
   logic status_take;

   // Result datapath.
   wire logic [5:0] flags;
   logic [31:0] flag_word;
   logic [31:0] bool_word;
   logic [31:0] data_next;
   logic [4:0] dest_next;
   logic valid_next;
   fcl_result_t result_reg;

   // Status word.
   wire logic [5:0] op_flags;
   wire logic [5:0] merged_flags;
   wire logic [5:0] psw_next;
   logic [5:0] psw_reg;

   // Refuse widths and delays that the datapath cannot serve.
   if (DATA_W != 32) begin : g_chk_data
      $error("Operands must be 32 bits wide.");
   end
   if (FLAG_W != 6) begin : g_chk_flag
      $error("The flag vector must be 6 bits wide.");
   end
   if (LATENCY != 1) begin : g_chk_lat
      $error("Only a one-cycle result delay is supported.");
   end
   if ((`FCL_INV_BIT >= FLAG_W) || (`FCL_IFZ_BIT >= FLAG_W)) begin : g_chk_bits
      $error("Flag positions lie outside the flag vector.");
   end

   // Less-than is greater-than with operands swapped, so one ordered compare serves both.
   fcl_cmp_core u_cmp (
      .a_in(ISSUE_IN.first_source),
      .b_in(ISSUE_IN.second_source),
      .lt_out(lt),
      .eq_out(eq),
      .nan_out(nan),
      .ifz_out(input_flush_zero_flag)
   );

   // Issue decode.
   always_comb begin
      issue_valid = ISSUE_IN.valid;
      guard_ok = issue_valid && ISSUE_IN.guard[0];
      op_is_flags = (ISSUE_IN.op == FCL_OP_LEQ_FLAGS);
      op_is_less = !op_is_flags;
      status_take = guard_ok && op_is_less;
   end

   // Flag vector, one bit at a time, in the status word layout.
   for (genvar k = 0; k < 6; k++) begin : g_flag_bit
      if (k == `FCL_INV_BIT) begin : g_inv
         assign flags[k] = nan;
      end else if (k == `FCL_IFZ_BIT) begin : g_ifz
         assign flags[k] = input_flush_zero_flag;
      end else begin : g_zero
         assign flags[k] = 1'b0;
      end
   end

   // Candidate destination words.
   always_comb begin
      flag_word = 32'h0;
      flag_word[5:0] = flags;
      bool_word = 32'h0;
      bool_word[0] = lt;
   end

   // Destination selection; an unknown code behaves as less-than.
   always_comb begin
      case (ISSUE_IN.op)
         FCL_OP_LEQ_FLAGS: begin
            data_next = flag_word;
         end
         FCL_OP_LESS: begin
            data_next = bool_word;
         end
         default: begin
            data_next = bool_word;
         end
      endcase
   end

   // Write-back qualifiers.
   always_comb begin
      valid_next = guard_ok;
      dest_next = ISSUE_IN.dest;
   end

   // Status word merge, one flag at a time.
   for (genvar k = 0; k < 6; k++) begin : g_psw_bit
      assign op_flags[k] = status_take & flags[k];
      assign merged_flags[k] = psw_reg[k] | OTHER_FLAGS_IN[k] | op_flags[k];
      assign psw_next[k] = PSW_WRITE_IN ? PSW_WDATA_IN[k] : merged_flags[k];
   end

   // Result register.
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         result_reg <= '0;
      end else begin
         result_reg.valid <= valid_next;
         result_reg.dest <= dest_next;
         result_reg.data <= data_next;
      end
   end

   // Flags compare never reaches the status word, so it is untouched by it.
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         psw_reg <= 6'h00;
      end else begin
         psw_reg <= psw_next;
      end
   end

   // Equality feeds only the core's less-than decision.
   logic eq_unused;
   assign eq_unused = eq;

   assign RESULT_OUT = result_reg;
   assign PSW_FLAGS_OUT = psw_reg;
endmodule
`default_nettype wire

// [test/fcl_unit_chk.sv]
// Checker for the compare unit ports.
`timescale 1ns/1ps
`default_nettype none
module fcl_unit_chk import fcl_pkg::*; (input wire logic MCLK_IN, input wire logic RST_IN,
   input wire fcl_issue_t ISSUE_IN, input wire logic [5:0] OTHER_FLAGS_IN,
   input wire logic PSW_WRITE_IN, input wire logic [5:0] PSW_WDATA_IN,
   input wire fcl_result_t RESULT_OUT, input wire logic [5:0] PSW_FLAGS_OUT);
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (RST_IN);
   wire logic tk = ISSUE_IN.valid & ISSUE_IN.guard[0];
   wire logic lq = ISSUE_IN.op == FCL_OP_LEQ_FLAGS;
   wire logic w = PSW_WRITE_IN;
   wire logic [5:0] p = PSW_FLAGS_OUT;
   wire logic [5:0] o = OTHER_FLAGS_IN;
   wire logic [31:0] r = RESULT_OUT.data;
   a_take_next: assert property (tk |=> RESULT_OUT.valid) else $error("late");
   a_guard_off: assert property (!tk |=> !RESULT_OUT.valid) else $error("guard");
   a_less_bool: assert property (tk && !lq |=> r[31:1] == 31'h0) else $error("bool");
   a_flag_layout: assert property (tk && lq |=> (r & ~32'h30) == 0) else $error("map");
   a_psw_quiet: assert property ((lq || !tk) && !w && o == 0 |=> $stable(p)) else $error("q");
   a_psw_sticky: assert property (!w |=> (p & $past(p)) == $past(p)) else $error("s");
   a_write_wins: assert property (w |=> p == $past(PSW_WDATA_IN)) else $error("w");
   a_other_or: assert property (!w |=> (p & $past(o)) == $past(o)) else $error("or");
endmodule
bind fcl_unit fcl_unit_chk chk(.*);
`default_nettype wire

// [test/fcl_core_model.sv]
// Register file that keeps the unit's results.
`timescale 1ns/1ps
`default_nettype none
module fcl_core_model import fcl_pkg::*; (input wire logic MCLK_IN, input wire fcl_result_t RES_IN);
   logic [31:0] regs [32];
   always_ff @(posedge MCLK_IN) if (RES_IN.valid) regs[RES_IN.dest] <= RES_IN.data;
endmodule
`default_nettype wire

// [test/tb_fcl_unit.sv]
// Bench for the compare unit.
`timescale 1ns/1ps
`default_nettype none
module tb_fcl_unit import fcl_pkg::*; ;
   logic clk = 0, rst = 1, pw = 0;
   logic [5:0] of = 0, wd = 0, psw;
   logic [31:0] q[$], r;
   logic [4:0] qd[$];
   fcl_issue_t iss = '0;
   fcl_result_t res;
   int err_total = 0, check_count = 0, seed = 32'h47eb, i = 0;
   always #2 clk = ~clk;
   fcl_unit dut(.MCLK_IN(clk), .RST_IN(rst), .ISSUE_IN(iss), .OTHER_FLAGS_IN(of),
      .PSW_WRITE_IN(pw), .PSW_WDATA_IN(wd), .RESULT_OUT(res), .PSW_FLAGS_OUT(psw));
   fcl_core_model core(.MCLK_IN(clk), .RES_IN(res));
   task cmp(string n, logic [31:0] e, logic [31:0] s);
      check_count++;
      if (e !== s) begin
         err_total++;
         $display("Error %s exp %h got %h", n, e, s);
      end
   endtask
   task print_verdict;
      if (q.size() != 0) err_total++;
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task op(logic l, logic [31:0] a, logic [31:0] b, logic g, logic [31:0] e);
      @(negedge clk);
      iss <= '{1'b1, l ? FCL_OP_LEQ_FLAGS : FCL_OP_LESS, a, b, {31'h0, g}, 5'(i)};
      if (g) begin
         q.push_back(e);
         qd.push_back(5'(i));
      end
   endtask
   task sw(logic [5:0] e);
      @(negedge clk);
      iss.valid <= 0;
      repeat (2) @(negedge clk);
      cmp("psw", 32'(e), 32'(psw));
   endtask
   always @(negedge clk) if (res.valid === 1'b1) begin
      cmp("res", q.size() ? q.pop_front() : 'x, res.data);
      cmp("dest", qd.size() ? 32'(qd.pop_front()) : 'x, 32'(res.dest));
   end
   initial begin
      #3000 err_total++;
      print_verdict;
   end
   initial begin
      repeat (6) @(negedge clk);
      rst <= 0;
      op(1, 32'h40400000, 0, 1, 0);
      op(1, 32'h40400000, 32'h7fffffff, 1, 32'h10);
      op(1, 32'h3f800000, 32'h00400000, 1, 32'h20);
      op(0, 32'h7fffffff, 0, 0, 0);
      sw(0);
      op(0, 32'h3f800000, 32'h40400000, 1, 1);
      op(0, 32'hff800000, 32'h7f800000, 1, 1);
      op(0, 32'h40400000, 32'h7fffffff, 1, 0);
      op(0, 32'h3f800000, 32'h00400000, 1, 0);
      of <= 6'h1;
      sw(6'h31);
      of <= 0;
      wd <= 6'($random(seed));
      pw <= 1;
      @(negedge clk);
      pw <= 0;
      sw(wd);
      for (i = 0; i < 40; i++) begin
         r = {9'h080, 23'($random(seed))};
         op(0, r, r + 1, 1'($random(seed)), 1);
         op(1, r + 1, r, 1, 0);
      end
      sw(wd);
      print_verdict;
   end
endmodule
`default_nettype wire
